// file: verilog/transport_conn_pkg.sv
// Shared constants and types for the transport connection manager.
package transport_conn_pkg;

  // Register bus geometry and byte addresses.
  localparam int              APB_AW        = 8;
  localparam logic [7:0]      ADDR_CTRL     = 8'h00;
  localparam logic [7:0]      ADDR_STAT     = 8'h04;
  localparam logic [7:0]      ADDR_SEQ      = 8'h08;
  localparam logic [7:0]      ADDR_INT_STAT = 8'h0C;
  localparam logic [7:0]      ADDR_INT_MASK = 8'h10;
  localparam logic [7:0]      ADDR_SEED     = 8'h14;

  // Control register bit positions.
  localparam int              CTRL_OPEN     = 0;
  localparam int              CTRL_CLOSE    = 1;
  localparam int              CTRL_LISTEN   = 2;
  localparam int              CTRL_DECLINE  = 3;

  // Sequence number geometry, field placement in the SEQ register and STAT bit positions.
  localparam int              SEQ_W_DEF     = 10;
  localparam int              SEQ_MOD_DEF   = 1000;
  localparam int              SEQ_EXP_LSB   = 16;
  localparam int              STAT_PEND_BIT = 4;
  localparam int              STAT_VLD_BIT  = 5;

  // Interrupt event bits.
  localparam int              IRQ_W         = 4;
  localparam int              IRQ_OPENED    = 0;
  localparam int              IRQ_CLOSED    = 1;
  localparam int              IRQ_DECLINED  = 2;
  localparam int              IRQ_REWIND    = 3;
  localparam logic [3:0]      INT_MASK_RST  = 4'h0;

  // Connection flag codes carried in the packet header.
  typedef enum logic [1:0]
  {
    FLAG_NONE  = 2'h0,
    FLAG_OPEN  = 2'h1,
    FLAG_CLOSE = 2'h2
  } flag_t;

  // Connection states, Gray coded along the initiator's open and close paths.
  typedef enum logic [2:0]
  {
    ST_CLOSED   = 3'h0,
    ST_OPENING  = 3'h1,
    ST_OPEN     = 3'h3,
    ST_CLOSING  = 3'h2,
    ST_ACCEPT   = 3'h5,
    ST_CLOSEACK = 3'h7
  } conn_state_t;

endpackage

// file: verilog/tx_header_reg.sv
// Output holding register for one outgoing transport packet header.
`timescale 1ns/10ps
module tx_header_reg
  import transport_conn_pkg::*;
#(
  parameter int SEQ_W = SEQ_W_DEF
)
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             load,
  input  wire logic [SEQ_W-1:0] ldSeq,
  input  wire logic [SEQ_W-1:0] ldAck,
  input  wire logic             ldAckValid,
  input  wire flag_t            ldFlag,
  input  wire logic             ldPayload,
  input  wire logic             txReady,
  output logic                  txValid,
  output logic      [SEQ_W-1:0] txSeq,
  output logic      [SEQ_W-1:0] txAck,
  output logic                  txAckValid,
  output flag_t                 txFlag,
  output logic                  txPayload
);

  // Valid rises on a load and falls once the link has taken the header.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      txValid <= 1'b0;
    else if (load)
      txValid <= 1'b1;
    else if (txReady)
      txValid <= 1'b0;
  end

  // Fields are only loaded while idle, so they stand until taken.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      txSeq      <= '0;
      txAck      <= '0;
      txAckValid <= 1'b0;
      txFlag     <= FLAG_NONE;
      txPayload  <= 1'b0;
    end
    else if (load)
    begin
      txSeq      <= ldSeq;
      txAck      <= ldAck;
      txAckValid <= ldAckValid;
      txFlag     <= ldFlag;
      txPayload  <= ldPayload;
    end
  end

  // A stalled header must not change under the link.
  a_tx_hold_stable: assert property (@(posedge clk) disable iff (!rst_b)
    txValid && !txReady |=> txValid && $stable(txSeq) && $stable(txFlag))
    else $error("Stalled header changed.");

endmodule

// file: verilog/transport_conn.sv
// Transport connection manager: open, run and close with a peer entity.
//
// What this block does
// - Open request carries open code, any sequence.
// - Open request marks acknowledge number invalid.
// - Accept open with open code, valid acknowledge.
// - Initiator sends plain ack; connection is open.
// - Either side may start closing.
// - Close request carries close code, advances sequence.
// - Close accept carries close code, advances sequence.
// - Requester acks close accept; connection closed.
// - Pending data may decline close by sending data.
// - Requester acks declined data and re-requests close.
// - Acknowledge number is next expected peer sequence.
// - Every payload packet received in OPEN or CLOSING is acknowledged.
// - Detect loss, retransmit from first unacknowledged.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module transport_conn
  import transport_conn_pkg::*;
#(
  parameter int SEQ_W   = SEQ_W_DEF,
  parameter int SEQ_MOD = SEQ_MOD_DEF
)
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  input  wire logic              rxValid,
  input  wire logic [SEQ_W-1:0]  rxSeq,
  input  wire logic [SEQ_W-1:0]  rxAck,
  input  wire logic              rxAckValid,
  input  wire flag_t             rxFlag,
  input  wire logic              rxPayload,
  input  wire logic              sendReq,
  output logic                   sendGrant,
  output logic                   txValid,
  input  wire logic              txReady,
  output logic      [SEQ_W-1:0]  txSeq,
  output logic      [SEQ_W-1:0]  txAck,
  output logic                   txAckValid,
  output flag_t                  txFlag,
  output logic                   txPayload,
  output logic                   rewind,
  output logic      [SEQ_W-1:0]  rewindSeq
);

  localparam logic [SEQ_W-1:0] SEQ_LAST = SEQ_W'(SEQ_MOD - 1);

  conn_state_t      state_r, state_nxt;
  flag_t            needFlag_r, needFlag_nxt;
  logic [SEQ_W-1:0] localSeq_r, expect_r, seed_r;
  logic             ackValid_r, ackPend_r, listen_r, allowDecline_r;
  logic [IRQ_W-1:0] intStat_r, intMask_r, evt;
  logic             apbWr, openCmd, closeCmd;
  logic             canSend, issue, issueFlag, issueData, issueAck;
  logic             rxCounted, rxInOrder, rxAckOk, rxTake, syncRx;
  logic             rewindHit, setAck;

  // Sequence numbers wrap modulo SEQ_MOD, as the peer expects.
  function automatic logic [SEQ_W-1:0] seqInc(input logic [SEQ_W-1:0] s);
    seqInc = (s == SEQ_LAST) ? '0 : s + 1'b1;
  endfunction

  // Address decode shared by the error answer.
  function automatic logic regHit(input logic [APB_AW-1:0] a);
    regHit = (a == ADDR_CTRL) || (a == ADDR_STAT) || (a == ADDR_SEQ) ||
             (a == ADDR_INT_STAT) || (a == ADDR_INT_MASK) ||
             (a == ADDR_SEED);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.

  // Zero wait states; read data is captured in the setup cycle.
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !regHit(paddr);
  assign apbWr    = psel && penable && pwrite && regHit(paddr);
  assign openCmd  = apbWr && paddr == ADDR_CTRL && pwdata[CTRL_OPEN];
  assign closeCmd = apbWr && paddr == ADDR_CTRL && pwdata[CTRL_CLOSE];

  // Read data register, loaded during the setup phase.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      prdata <= '0;
    else if (psel && !penable)
    begin
      prdata <= '0;
      unique case (paddr)
        ADDR_CTRL:
        begin
          prdata[CTRL_LISTEN]  <= listen_r;
          prdata[CTRL_DECLINE] <= allowDecline_r;
        end
        ADDR_STAT:
        begin
          prdata[2:0]           <= state_r;
          prdata[STAT_PEND_BIT] <= ackPend_r;
          prdata[STAT_VLD_BIT]  <= ackValid_r;
        end
        ADDR_SEQ:
        begin
          prdata[SEQ_W-1:0]                   <= localSeq_r;
          prdata[SEQ_EXP_LSB+SEQ_W-1:SEQ_EXP_LSB] <= expect_r;
        end
        ADDR_INT_STAT: prdata[IRQ_W-1:0] <= intStat_r;
        ADDR_INT_MASK: prdata[IRQ_W-1:0] <= intMask_r;
        ADDR_SEED:     prdata[SEQ_W-1:0] <= seed_r;
        default:       prdata <= '0;
      endcase
    end
  end

  // Software configuration: listening, declining and the starting number.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      listen_r       <= 1'b0;
      allowDecline_r <= 1'b0;
      seed_r         <= '0;
      intMask_r      <= INT_MASK_RST;
    end
    else if (apbWr)
    begin
      if (paddr == ADDR_CTRL)
      begin
        listen_r       <= pwdata[CTRL_LISTEN];
        allowDecline_r <= pwdata[CTRL_DECLINE];
      end
      if (paddr == ADDR_SEED)
        seed_r <= pwdata[SEQ_W-1:0];
      if (paddr == ADDR_INT_MASK)
        intMask_r <= pwdata[IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive side classification.

  assign rxCounted = rxPayload || (rxFlag != FLAG_NONE);
  assign rxInOrder = (rxSeq == expect_r);
  assign rxAckOk   = rxAckValid && (rxAck == localSeq_r);
  assign rxTake    = rxValid && rxCounted && rxInOrder &&
                     (state_r == ST_OPEN || state_r == ST_CLOSING);

  // A lagging acknowledgement means our packets were lost after it.
  assign rewindHit = rxValid && rxAckValid && state_r == ST_OPEN &&
                     rxAck != localSeq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Connection state.

  // Next state and the flag packet owed to the peer.
  always_comb
  begin
    state_nxt    = state_r;
    needFlag_nxt = issueFlag ? FLAG_NONE : needFlag_r;
    evt          = '0;
    evt[IRQ_REWIND] = rewindHit;
    unique case (state_r)
      ST_CLOSED:
        if (openCmd)
        begin
          state_nxt    = ST_OPENING;
          needFlag_nxt = FLAG_OPEN;
        end
        else if (rxValid && listen_r && rxFlag == FLAG_OPEN && !rxAckValid)
        begin
          state_nxt    = ST_ACCEPT;
          needFlag_nxt = FLAG_OPEN;
        end
      ST_OPENING:
        if (rxValid && rxFlag == FLAG_OPEN && rxAckOk)
        begin
          state_nxt       = ST_OPEN;
          evt[IRQ_OPENED] = 1'b1;
        end
      ST_ACCEPT:
        if (rxValid && rxFlag == FLAG_NONE && rxAckOk)
        begin
          state_nxt       = ST_OPEN;
          evt[IRQ_OPENED] = 1'b1;
        end
      ST_OPEN:
        if (rxValid && rxFlag == FLAG_CLOSE && rxInOrder)
        begin
          // Declining keeps the link open so the pending data can go out.
          if (!(allowDecline_r && sendReq))
          begin
            state_nxt    = ST_CLOSEACK;
            needFlag_nxt = FLAG_CLOSE;
          end
        end
        else if (closeCmd)
        begin
          state_nxt    = ST_CLOSING;
          needFlag_nxt = FLAG_CLOSE;
        end
      ST_CLOSING:
        if (rxValid && rxInOrder)
        begin
          if (rxFlag == FLAG_CLOSE)
          begin
            state_nxt       = ST_CLOSED;
            evt[IRQ_CLOSED] = 1'b1;
          end
          else if (rxPayload)
          begin
            needFlag_nxt      = FLAG_CLOSE;
            evt[IRQ_DECLINED] = 1'b1;
          end
        end
      ST_CLOSEACK:
        if (rxValid && rxFlag == FLAG_NONE && rxAckOk)
        begin
          state_nxt       = ST_CLOSED;
          evt[IRQ_CLOSED] = 1'b1;
        end
      default:
        state_nxt = ST_CLOSED;
    endcase
  end

  // State and owed flag registers.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_r    <= ST_CLOSED;
      needFlag_r <= FLAG_NONE;
    end
    else
    begin
      state_r    <= state_nxt;
      needFlag_r <= needFlag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence and acknowledge numbers.

  assign syncRx = rxValid && rxFlag == FLAG_OPEN &&
                  (state_nxt == ST_ACCEPT ||
                   (state_r == ST_OPENING && state_nxt == ST_OPEN));
  // Out-of-order payload is answered too: the stale number flags the loss.
  assign setAck = (syncRx && state_r == ST_OPENING) ||
                  (rxValid && rxCounted &&
                   (state_r == ST_OPEN || state_r == ST_CLOSING));

  // Local numbering restarts from the seed each time a connection opens.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      localSeq_r <= '0;
    else if (state_r == ST_CLOSED && state_nxt != ST_CLOSED)
      localSeq_r <= seed_r;
    else if (rewindHit)
      localSeq_r <= rxAck;
    else if (issueFlag || issueData)
      localSeq_r <= seqInc(localSeq_r);
  end

  // Peer numbering: expected number and whether it is valid yet.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      expect_r   <= '0;
      ackValid_r <= 1'b0;
    end
    else
    begin
      if (syncRx || rxTake)
        expect_r <= seqInc(rxSeq);
      if (syncRx)
        ackValid_r <= 1'b1;
      else if (state_r == ST_CLOSED && openCmd)
        ackValid_r <= 1'b0;
    end
  end

  // Owed acknowledgement; a new arrival wins over the send that clears it.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      ackPend_r <= 1'b0;
    else
      ackPend_r <= setAck || (ackPend_r && !issue);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit selection: flag packet, then data, then a plain ack.

  // Nothing is issued while a header is received, so numbers are settled.
  assign canSend   = !txValid && !rxValid;
  assign issueFlag = canSend && needFlag_r != FLAG_NONE;
  assign issueData = canSend && !issueFlag && sendReq &&
                     state_r == ST_OPEN;
  assign issueAck  = canSend && !issueFlag && !issueData && ackPend_r;
  assign issue     = issueFlag || issueData || issueAck;
  assign sendGrant = issueData;

  tx_header_reg #(
    .SEQ_W      (SEQ_W)
  ) u_tx (
    .clk        (clk),
    .rst_b      (rst_b),
    .load       (issue),
    .ldSeq      (localSeq_r),
    .ldAck      (expect_r),
    .ldAckValid (ackValid_r),
    .ldFlag     (issueFlag ? needFlag_r : FLAG_NONE),
    .ldPayload  (issueData),
    .txReady    (txReady),
    .txValid    (txValid),
    .txSeq      (txSeq),
    .txAck      (txAck),
    .txAckValid (txAckValid),
    .txFlag     (txFlag),
    .txPayload  (txPayload)
  );

  // Rewind notice tells the user where to resend from.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rewind    <= 1'b0;
      rewindSeq <= '0;
    end
    else
    begin
      rewind <= rewindHit;
      if (rewindHit)
        rewindSeq <= rxAck;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, write one to clear, set wins.

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      intStat_r <= '0;
    else if (apbWr && paddr == ADDR_INT_STAT)
      intStat_r <= (intStat_r & ~pwdata[IRQ_W-1:0]) | evt;
    else
      intStat_r <= intStat_r | evt;
  end

  assign irq = |(intStat_r & intMask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_open_req_flag: assert property (
    state_r == ST_OPENING && issueFlag |=> txFlag == FLAG_OPEN && !txPayload)
    else $error("Open request malformed.");

  a_open_ack_invalid: assert property (
    state_r == ST_OPENING && issueFlag |=> txFlag == FLAG_OPEN && !txAckValid)
    else $error("Open request ack not invalid.");

  a_accept_reply: assert property (
    state_r == ST_ACCEPT && issueFlag |=>
      txFlag == FLAG_OPEN && txAckValid && txAck == $past(expect_r))
    else $error("Open accept malformed.");

  a_open_final_ack: assert property (
    state_r == ST_OPENING && state_nxt == ST_OPEN |=>
      state_r == ST_OPEN && ackPend_r)
    else $error("No final ack after accept.");

  a_close_advances: assert property (
    issueFlag && needFlag_r == FLAG_CLOSE |=>
      localSeq_r == seqInc($past(localSeq_r)))
    else $error("Close did not advance sequence.");

  a_pure_ack_seq: assert property (
    issueAck |=> localSeq_r == $past(localSeq_r) && txFlag == FLAG_NONE)
    else $error("Plain ack advanced sequence.");

  // A held data header may outlive OPEN only while a close is under way.
  a_data_when_open: assert property (
    txValid && txPayload |-> state_r == ST_OPEN ||
      state_r == ST_CLOSING || state_r == ST_CLOSEACK)
    else $error("Data sent outside open state.");

  a_decline_stays: assert property (
    state_r == ST_OPEN && rxValid && rxFlag == FLAG_CLOSE && rxInOrder &&
    allowDecline_r && sendReq |=> state_r == ST_OPEN && ackPend_r)
    else $error("Decline did not keep link open.");

  a_reclose: assert property (
    state_r == ST_CLOSING && rxValid && rxInOrder &&
    rxFlag == FLAG_NONE && rxPayload |=> needFlag_r == FLAG_CLOSE)
    else $error("Close not restarted.");

  a_close_done: assert property (
    state_r == ST_CLOSING && rxValid && rxInOrder && rxFlag == FLAG_CLOSE
    |=> state_r == ST_CLOSED && ackPend_r)
    else $error("Close accept not acknowledged.");

  a_ack_expected: assert property (
    rxTake |=> expect_r == seqInc($past(rxSeq)))
    else $error("Expected number wrong.");

endmodule

// file: verification/peer_entity.sv
// Behavioural peer transport entity on the far side of the link.
`timescale 1ns/10ps
module peer_entity
  import transport_conn_pkg::*;
#(
  parameter int PEER_SEED = 456
)
(
  input  wire logic       clk,
  input  wire logic       txValid,
  output logic            txReady,
  input  wire logic [9:0] txSeq,
  input  wire logic [9:0] txAck,
  input  wire logic       txAckValid,
  input  wire flag_t      txFlag,
  input  wire logic       txPayload,
  output logic            rxValid,
  output logic      [9:0] rxSeq,
  output logic      [9:0] rxAck,
  output logic            rxAckValid,
  output flag_t           rxFlag,
  output logic            rxPayload
);
  logic [23:0] got[$];
  int          pSeq    = PEER_SEED;
  int          expSeq  = 0;
  int          lag     = 0;
  int          stall   = 1;
  int          waitCnt = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs start quiet so the design never sees an unknown header.
  initial
  begin
    txReady    = 1'b0;
    rxValid    = 1'b0;
    rxSeq      = 10'h0;
    rxAck      = 10'h0;
    rxAckValid = 1'b0;
    rxFlag     = FLAG_NONE;
    rxPayload  = 1'b0;
  end

  // Take a header after a stall, so the design must hold it meanwhile.
  always @(posedge clk)
  begin
    if (txValid && txReady)
    begin
      got.push_back({txFlag, txPayload, txAckValid, txSeq, txAck});
      if (txFlag != FLAG_NONE || txPayload)
        expSeq <= (int'(txSeq) + 1) % SEQ_MOD_DEF;
      txReady <= 1'b0;
      waitCnt <= 0;
    end
    else if (txValid)
    begin
      txReady <= (waitCnt >= stall);
      waitCnt <= waitCnt + 1;
    end
  end

  // Send n headers back to back; lag makes the ack trail on purpose.
  task automatic send(input flag_t f, input logic pay, input logic ackv,
                      input int n);
    repeat (n)
    begin
      @(posedge clk);
      rxValid    <= 1'b1;
      rxSeq      <= 10'(pSeq);
      rxAck      <= ackv ? 10'((expSeq + SEQ_MOD_DEF - lag) % SEQ_MOD_DEF)
                         : ~10'(expSeq);
      rxAckValid <= ackv;
      rxFlag     <= f;
      rxPayload  <= pay;
      if (f != FLAG_NONE || pay)
        pSeq = (pSeq + 1) % SEQ_MOD_DEF;
    end
    @(posedge clk);
    rxValid <= 1'b0;
    rxSeq   <= ~rxSeq; // Released fields must not keep looking valid.
    rxAck   <= ~rxAck;
  endtask
endmodule

// file: verification/transport_connection_handshake_test.sv
// Self-checking bench for the transport connection manager.
`timescale 1ns/10ps
module transport_connection_handshake_test import transport_conn_pkg::*;;
  logic        clk = 1'b0;
  logic        rstB = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, sendGrant, txValid, txReady;
  logic        rxValid, rxAckValid, rxPayload, txAckValid, txPayload;
  logic [9:0]  rxSeq, rxAck, txSeq, txAck, rewindSeq;
  flag_t       rxFlag, txFlag;
  logic        sendReq = 1'b0;
  logic        rewind;
  logic        rwSeen = 1'b0;
  logic [9:0]  rwSeq = 10'h0;
  logic [31:0] rdv;
  logic        err;
  int          nMismatch = 0;
  int          numChecks = 0;
  int          cyc = 0;

  ////////////////////////////////////////////////////////////////////////////
  // A 200 MHz clock.
  always #2.5 clk = ~clk;

  transport_conn #(.SEQ_W(10), .SEQ_MOD(1000)) dut (
    .clk(clk), .rst_b(rstB), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .rxValid(rxValid), .rxSeq(rxSeq),
    .rxAck(rxAck), .rxAckValid(rxAckValid), .rxFlag(rxFlag),
    .rxPayload(rxPayload), .sendReq(sendReq), .sendGrant(sendGrant),
    .txValid(txValid), .txReady(txReady), .txSeq(txSeq), .txAck(txAck),
    .txAckValid(txAckValid), .txFlag(txFlag), .txPayload(txPayload),
    .rewind(rewind), .rewindSeq(rewindSeq));

  peer_entity p (
    .clk(clk), .txValid(txValid), .txReady(txReady), .txSeq(txSeq),
    .txAck(txAck), .txAckValid(txAckValid), .txFlag(txFlag),
    .txPayload(txPayload), .rxValid(rxValid), .rxSeq(rxSeq), .rxAck(rxAck),
    .rxAckValid(rxAckValid), .rxFlag(rxFlag), .rxPayload(rxPayload));

  ////////////////////////////////////////////////////////////////////////////
  // The user drops its request once granted; one-cycle pulses are latched.
  always @(posedge clk)
  begin
    if (sendGrant === 1'b1)
      sendReq <= 1'b0;
    if (rewind === 1'b1)
    begin
      rwSeen <= 1'b1;
      rwSeq  <= rewindSeq;
    end
  end

  // A hang is cut short well past the fewer than 200 cycles the tests need.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      nMismatch++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (nMismatch == 0 && numChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdv, err);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rdv, err);
    check(rdv, exp);
  endtask

  // Irq is read one edge after a write so the write has landed.
  task automatic irq_chk(input logic exp);
    @(posedge clk);
    check({31'h0, irq}, {31'h0, exp});
  endtask

  // Compare the next header taken by the peer; an invalid ack is free.
  task automatic exp_tx(input flag_t f, input logic pay, input logic ackv,
                        input int s, input int a);
    logic [23:0] h;
    while (p.got.size() == 0)
      @(posedge clk);
    h = p.got.pop_front();
    check({8'h00, h}, {8'h00, f, pay, ackv, 10'(s),
                       ackv ? 10'(a) : h[9:0]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset state, open, data, both closes, rewind.
  initial
  begin
    repeat (3) @(posedge clk);
    rstB <= 1'b1;
    rd_chk(ADDR_STAT, 32'h0);
    rd_chk(ADDR_INT_MASK, {28'h0, INT_MASK_RST});
    rd_chk(ADDR_SEED, 32'h0);
    rd_chk(ADDR_CTRL, 32'h0);
    apb(1'b0, 8'h1C, 32'h0, rdv, err);
    check({31'h0, err}, 32'h1);
    check(rdv, 32'h0);
    wr(ADDR_SEED, 32'h315);
    wr(ADDR_INT_MASK, 32'hF);
    wr(ADDR_CTRL, 32'h1);
    exp_tx(FLAG_OPEN, 1'b0, 1'b0, 789, 0);
    p.send(FLAG_OPEN, 1'b0, 1'b1, 1);
    exp_tx(FLAG_NONE, 1'b0, 1'b1, 790, 457);
    rd_chk(ADDR_STAT, 32'h23);
    irq_chk(1'b1);
    wr(ADDR_INT_STAT, 32'h1);
    irq_chk(1'b0);
    sendReq <= 1'b1;
    exp_tx(FLAG_NONE, 1'b1, 1'b1, 790, 457);
    p.send(FLAG_NONE, 1'b0, 1'b1, 1);
    repeat (10) @(posedge clk);
    check(32'(p.got.size()), 32'h0);
    p.send(FLAG_NONE, 1'b1, 1'b1, 2);
    exp_tx(FLAG_NONE, 1'b0, 1'b1, 791, 459);
    wr(ADDR_CTRL, 32'h2);
    exp_tx(FLAG_CLOSE, 1'b0, 1'b1, 791, 459);
    p.send(FLAG_NONE, 1'b1, 1'b1, 1);
    exp_tx(FLAG_CLOSE, 1'b0, 1'b1, 792, 460);
    rd_chk(ADDR_INT_STAT, 32'h4);
    p.send(FLAG_CLOSE, 1'b0, 1'b1, 1);
    exp_tx(FLAG_NONE, 1'b0, 1'b1, 793, 461);
    rd_chk(ADDR_STAT, 32'h20);
    rd_chk(ADDR_SEQ, 32'h01CD0319);
    irq_chk(1'b1);
    wr(ADDR_INT_MASK, 32'h0);
    irq_chk(1'b0);
    rd_chk(ADDR_INT_STAT, 32'h6);
    wr(ADDR_INT_STAT, 32'h6);
    rd_chk(ADDR_INT_STAT, 32'h0);
    wr(ADDR_INT_MASK, 32'hF);
    // Peer opens, then closes while the user still holds data.
    wr(ADDR_SEED, 32'h64);
    wr(ADDR_CTRL, 32'hC);
    p.send(FLAG_OPEN, 1'b0, 1'b0, 1);
    exp_tx(FLAG_OPEN, 1'b0, 1'b1, 100, 462);
    p.send(FLAG_NONE, 1'b0, 1'b1, 1);
    rd_chk(ADDR_STAT, 32'h23);
    fork
      p.send(FLAG_CLOSE, 1'b0, 1'b1, 1);
      begin
        @(posedge clk);
        sendReq <= 1'b1;
      end
    join
    exp_tx(FLAG_NONE, 1'b1, 1'b1, 101, 463);
    p.send(FLAG_CLOSE, 1'b0, 1'b1, 1);
    exp_tx(FLAG_CLOSE, 1'b0, 1'b1, 102, 464);
    p.send(FLAG_NONE, 1'b0, 1'b1, 1);
    rd_chk(ADDR_STAT, 32'h20);
    // Reopen and answer a data packet with a trailing ack.
    p.send(FLAG_OPEN, 1'b0, 1'b0, 1);
    exp_tx(FLAG_OPEN, 1'b0, 1'b1, 100, 465);
    p.send(FLAG_NONE, 1'b0, 1'b1, 1);
    sendReq <= 1'b1;
    exp_tx(FLAG_NONE, 1'b1, 1'b1, 101, 465);
    check({31'h0, rwSeen}, 32'h0);
    p.lag = 1;
    p.send(FLAG_NONE, 1'b0, 1'b1, 1);
    repeat (3) @(posedge clk);
    check({31'h0, rwSeen}, 32'h1);
    check({22'h0, rwSeq}, 32'h65);
    apb(1'b0, ADDR_INT_STAT, 32'h0, rdv, err);
    check({31'h0, rdv[IRQ_REWIND]}, 32'h1);
    // The next data packet must reuse the first unacknowledged number.
    sendReq <= 1'b1;
    exp_tx(FLAG_NONE, 1'b1, 1'b1, 101, 465);
    print_verdict();
  end
endmodule
